// [core/dbot_pkg.sv]
// Shared constants for the burst, latency and termination timing block.
// Assumes one 20 MHz clock and command pins synchronised and decoded in the core.
package dbot_pkg;
  // Command codes on {rasN, casN, weN} while chip select is low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_ZQ = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // Burst-length field of mode register zero
  localparam logic [1:0] BLF_FIXED8 = 2'h0;
  localparam logic [1:0] BLF_PERCMD = 2'h1;
  localparam logic [1:0] BLF_FIXED4 = 2'h2;
  // Beats per burst, one beat per clock
  localparam logic [3:0] BEATS_LONG = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;
  // Termination hold counts in clock cycles
  localparam logic [3:0] HOLD_SHORT = 4'h4;
  localparam logic [3:0] HOLD_LONG = 4'h6;
  // Latency field width, pipeline depth, data width and write-buffer depth
  localparam int LAT_W = 6;
  localparam int LAT_DEPTH = 64;
  localparam int DQ_W = 16;
  localparam int BUF_DEPTH = 16;
  // Reset values
  localparam logic [LAT_W-1:0] LAT_RST = 6'h00;
  localparam logic [7:0] BANKS_RST = 8'h00;
  // Control pins at rest: deselect, nop code, clock enable high
  localparam logic [11:0] PIN_CTRL_RST = 12'hf02;
endpackage

// [core/dbot_fifo_if.sv]
// Valid/ready carrier between the timing core and its write buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface dbot_fifo_if #(parameter int WIDTH = 16);
  logic inValid;
  logic inReady;
  logic [WIDTH-1:0] inData;
  logic outValid;
  logic outReady;
  logic [WIDTH-1:0] outData;
  modport fill (output inValid, output inData, input inReady);
  modport buffer (input inValid, input inData, output inReady,
    output outValid, output outData, input outReady);
endinterface

// [core/dbot_fifo.sv]
// Write-data buffer with registered flags and registered read data.
// Assumes the drain side may hold outReady low for any length of time.
`timescale 1ns/1ps
module dbot_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Source and drain
  dbot_fifo_if.buffer port,
  // Drain-side handshake copied out as plain ports
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("dbot_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic fullReg;
  logic outValid_reg;
  logic [WIDTH-1:0] outData_reg;
  logic push;
  logic pop;

  assign push = port.inValid && !fullReg;
  // Output stage refills whenever it is empty or being taken
  assign pop = (count_reg != '0) && (!outValid_reg || outReady);
  assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign port.inReady = !fullReg;
  assign port.outValid = outValid_reg;
  assign port.outData = outData_reg;
  assign outValid = outValid_reg;
  assign outData = outData_reg;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= port.inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      fullReg <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= count_next;
      fullReg <= (count_next == DEPTH[AW:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      outValid_reg <= 1'b0;
      outData_reg <= '0;
    end else if (pop) begin
      outValid_reg <= 1'b1;
      outData_reg <= mem[rdPtr_reg];
    end else if (outReady) begin
      outValid_reg <= 1'b0;
    end
  end
endmodule

// [core/dbot_core.sv]
// Device-side burst length, latency and termination timing for the DRAM.
// Assumes command pins arrive from the controller on its own timing and
// are synchronised here; array data are same-clock logic.
//
// Functional notes
// - Field 00, or 01 with chop bit 1: eight beats
// - Field 10: every burst chopped to four
// - Field 01, write with chop bit 0: four beats
// - Per-command mode: each read takes its own length
// - Async termination window lasts write latency minus one
`timescale 1ns/1ps
module dbot_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Mode settings
  input wire logic [1:0] burstLenField,
  input wire logic [dbot_pkg::LAT_W-1:0] additiveLatency,
  input wire logic [dbot_pkg::LAT_W-1:0] columnLatency,
  input wire logic [dbot_pkg::LAT_W-1:0] writeColumnLatency,
  // Command pins
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [2:0] bankAddr,
  input wire logic allBanksBit,
  input wire logic burstChopAddressBit,
  input wire logic terminationEnable,
  input wire logic clockEnable,
  // Data pins
  input wire logic [dbot_pkg::DQ_W-1:0] dqIn,
  output logic [dbot_pkg::DQ_W-1:0] dqOut,
  output logic dqOe,
  // Array side
  input wire logic [dbot_pkg::DQ_W-1:0] arrayRdData,
  output logic storeValid,
  output logic [dbot_pkg::DQ_W-1:0] storeData,
  input wire logic storeReady,
  // Status
  output logic chopActive,
  output logic asyncTermination,
  output logic termHoldError,
  output logic powerDownError,
  output logic writeOverflow
);
  localparam int LW = dbot_pkg::LAT_W;
  localparam int PW = 4 + 3 + 1 + 1 + 1 + 1 + 1 + dbot_pkg::DQ_W;

  // ****************************************
  // Input synchroniser
  // ****************************************
  logic [PW-1:0] pinMeta_reg;
  logic [PW-1:0] pinSync_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      // Reset to the pins' idle levels so no false clock-enable edge follows
      pinMeta_reg <= {dbot_pkg::PIN_CTRL_RST, {dbot_pkg::DQ_W{1'b0}}};
      pinSync_reg <= {dbot_pkg::PIN_CTRL_RST, {dbot_pkg::DQ_W{1'b0}}};
    end else begin
      pinMeta_reg <= {csN, rasN, casN, weN, bankAddr, allBanksBit,
        burstChopAddressBit, terminationEnable, clockEnable, 1'b0, dqIn};
      pinSync_reg <= pinMeta_reg;
    end
  end

  logic sCsN;
  logic [2:0] sCmd;
  logic [2:0] sBank;
  logic sAll;
  logic sChop;
  logic sOdt;
  logic sCke;
  logic [dbot_pkg::DQ_W-1:0] sDq;
  logic unusedPad;
  assign {sCsN, sCmd, sBank, sAll, sChop, sOdt, sCke, unusedPad, sDq} =
    pinSync_reg;

  logic isRd;
  logic isWr;
  logic isAct;
  logic isPre;
  assign isRd = !sCsN && sCmd == dbot_pkg::CMD_RD;
  assign isWr = !sCsN && sCmd == dbot_pkg::CMD_WR;
  assign isAct = !sCsN && sCmd == dbot_pkg::CMD_ACT;
  assign isPre = !sCsN && sCmd == dbot_pkg::CMD_PRE;

  // ****************************************
  // Burst length and latency
  // ****************************************
  logic cmdChop;
  always_comb begin
    unique case (burstLenField)
      dbot_pkg::BLF_FIXED8: cmdChop = 1'b0;
      dbot_pkg::BLF_PERCMD: cmdChop = !sChop;
      dbot_pkg::BLF_FIXED4: cmdChop = 1'b1;
      default: cmdChop = 1'b0;
    endcase
  end

  logic [LW-1:0] rdLat;
  logic [LW-1:0] wrLat;
  assign rdLat = additiveLatency + columnLatency;
  assign wrLat = additiveLatency + writeColumnLatency;

  // Write beats are taken one cycle after the counter loads, so the write
  // marker starts one slot nearer; latencies below two are served as two
  logic [LW-1:0] wrSlot;
  assign wrSlot = (wrLat < LW'(2)) ? '0 : wrLat - LW'(2);

  // Pipelines carry a start marker and its chop flag toward slot zero.
  // The sync delay hits commands and data alike, so alignment holds.
  logic [dbot_pkg::LAT_DEPTH-1:0] rdPipe_reg;
  logic [dbot_pkg::LAT_DEPTH-1:0] rdChopPipe_reg;
  logic [dbot_pkg::LAT_DEPTH-1:0] wrPipe_reg;
  logic [dbot_pkg::LAT_DEPTH-1:0] wrChopPipe_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdPipe_reg <= '0;
      rdChopPipe_reg <= '0;
      wrPipe_reg <= '0;
      wrChopPipe_reg <= '0;
    end else begin
      rdPipe_reg <= rdPipe_reg >> 1;
      rdChopPipe_reg <= rdChopPipe_reg >> 1;
      wrPipe_reg <= wrPipe_reg >> 1;
      wrChopPipe_reg <= wrChopPipe_reg >> 1;
      // A zero latency is served as one cycle, the least the pipe allows
      if (isRd) begin
        rdPipe_reg[(rdLat == '0) ? 0 : rdLat - 1'b1] <= 1'b1;
        rdChopPipe_reg[(rdLat == '0) ? 0 : rdLat - 1'b1] <= cmdChop;
      end
      if (isWr) begin
        wrPipe_reg[wrSlot] <= 1'b1;
        wrChopPipe_reg[wrSlot] <= cmdChop;
      end
    end
  end

  // ****************************************
  // Data beats
  // ****************************************
  logic [3:0] rdBeats_reg;
  logic [3:0] wrBeats_reg;
  dbot_fifo_if #(.WIDTH(dbot_pkg::DQ_W)) wbuf ();

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdBeats_reg <= 4'h0;
      wrBeats_reg <= 4'h0;
      chopActive <= 1'b0;
      dqOut <= '0;
      dqOe <= 1'b0;
    end else begin
      if (rdPipe_reg[0]) begin
        rdBeats_reg <= rdChopPipe_reg[0] ? dbot_pkg::BEATS_CHOP
          : dbot_pkg::BEATS_LONG;
        chopActive <= rdChopPipe_reg[0];
      end else if (rdBeats_reg != 4'h0) begin
        rdBeats_reg <= rdBeats_reg - 4'h1;
      end
      if (wrPipe_reg[0]) begin
        wrBeats_reg <= wrChopPipe_reg[0] ? dbot_pkg::BEATS_CHOP
          : dbot_pkg::BEATS_LONG;
        chopActive <= wrChopPipe_reg[0];
      end else if (wrBeats_reg != 4'h0) begin
        wrBeats_reg <= wrBeats_reg - 4'h1;
      end
      dqOe <= rdBeats_reg != 4'h0;
      dqOut <= (rdBeats_reg != 4'h0) ? arrayRdData : '0;
    end
  end

  // Write beats go to the buffer; a full buffer drops the beat
  assign wbuf.inValid = wrBeats_reg != 4'h0;
  assign wbuf.inData = sDq;
  assign wbuf.outReady = storeReady;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      writeOverflow <= 1'b0;
    end else if (wbuf.inValid && !wbuf.inReady) begin
      writeOverflow <= 1'b1;
    end
  end

  dbot_fifo #(
    .WIDTH(dbot_pkg::DQ_W),
    .DEPTH(dbot_pkg::BUF_DEPTH)
  ) u_wbuf (
    .clk(clk),
    .rstn(rstn),
    .port(wbuf),
    .outValid(storeValid),
    .outData(storeData),
    .outReady(storeReady)
  );

  // ****************************************
  // Termination hold check
  // ****************************************
  logic odtPrev_reg;
  logic [3:0] holdCnt_reg;
  logic [3:0] holdWr;
  assign holdWr = cmdChop ? dbot_pkg::HOLD_SHORT : dbot_pkg::HOLD_LONG;
  logic [3:0] holdRise;
  logic [3:0] holdLoad;
  logic [3:0] holdLeft;
  assign holdRise = (sOdt && !odtPrev_reg) ? dbot_pkg::HOLD_SHORT - 4'h1
    : 4'h0;
  // A write that comes with the rising enable must still win
  assign holdLoad = (isWr && sOdt && holdWr - 4'h1 > holdRise)
    ? holdWr - 4'h1 : holdRise;
  assign holdLeft = (holdCnt_reg != 4'h0) ? holdCnt_reg - 4'h1 : 4'h0;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      odtPrev_reg <= 1'b0;
      holdCnt_reg <= 4'h0;
      termHoldError <= 1'b0;
    end else begin
      odtPrev_reg <= sOdt;
      // Both windows run; the longer remainder governs
      holdCnt_reg <= (holdLoad > holdLeft) ? holdLoad : holdLeft;
      if (!sOdt && odtPrev_reg && holdCnt_reg != 4'h0) begin
        termHoldError <= 1'b1;
      end
    end
  end

  // ****************************************
  // Power-down entry
  // ****************************************
  logic ckePrev_reg;
  logic [7:0] openBanks_reg;
  logic lastOk_reg;
  logic [LW-1:0] asyncCnt_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      openBanks_reg <= dbot_pkg::BANKS_RST;
      lastOk_reg <= 1'b1;
    end else if (sCke) begin
      if (isAct) begin
        openBanks_reg[sBank] <= 1'b1;
      end else if (isPre) begin
        if (sAll) begin
          openBanks_reg <= dbot_pkg::BANKS_RST;
        end else begin
          openBanks_reg[sBank] <= 1'b0;
        end
      end
      lastOk_reg <= sCsN || isAct || isPre || sCmd == dbot_pkg::CMD_NOP;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ckePrev_reg <= 1'b1;
      powerDownError <= 1'b0;
      asyncCnt_reg <= dbot_pkg::LAT_RST;
      asyncTermination <= 1'b0;
    end else begin
      ckePrev_reg <= sCke;
      if (ckePrev_reg && !sCke && openBanks_reg != 8'h00 && !lastOk_reg) begin
        powerDownError <= 1'b1;
      end
      if (ckePrev_reg != sCke) begin
        asyncCnt_reg <= (wrLat > LW'(1)) ? wrLat - LW'(1) : LW'(1);
        asyncTermination <= 1'b1;
      end else if (asyncCnt_reg > LW'(1)) begin
        asyncCnt_reg <= asyncCnt_reg - LW'(1);
      end else begin
        asyncCnt_reg <= dbot_pkg::LAT_RST;
        asyncTermination <= 1'b0;
      end
    end
  end
endmodule

// [verification/dbot_checker.sv]
// Port-level assertions for the timing core.
// Assumes the core's top ports only; bound in below.
`timescale 1ns/1ps
module dbot_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Observed inputs
  input wire logic [1:0] burstLenField,
  input wire logic clockEnable,
  input wire logic storeReady,
  // Observed outputs
  input wire logic [dbot_pkg::DQ_W-1:0] dqOut,
  input wire logic dqOe,
  input wire logic storeValid,
  input wire logic [dbot_pkg::DQ_W-1:0] storeData,
  input wire logic chopActive,
  input wire logic asyncTermination,
  input wire logic termHoldError,
  input wire logic powerDownError,
  input wire logic writeOverflow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_idle_data_zero: assert property (!dqOe |-> dqOut == '0)
    else $error("Read data driven while idle");
  a_long_burst: assert property (
    $rose(dqOe) && !chopActive |-> dqOe [*8] ##1 !dqOe)
    else $error("Eight-beat burst has wrong length");
  a_chop_burst: assert property (
    $rose(dqOe) && chopActive |-> dqOe [*4] ##1 !dqOe)
    else $error("Chopped burst has wrong length");
  a_fixed_four: assert property (
    burstLenField == dbot_pkg::BLF_FIXED4 && $rose(dqOe) |-> chopActive)
    else $error("Fixed four-beat mode did not chop");
  a_async_window: assert property (
    $changed(clockEnable) |-> ##[1:6] asyncTermination)
    else $error("No async termination window after clock-enable edge");
  a_store_held: assert property (
    storeValid && !storeReady |=> storeValid && $stable(storeData))
    else $error("Buffer output changed while stalled");
  a_errors_sticky: assert property (
    !($fell(termHoldError) || $fell(powerDownError) || $fell(writeOverflow)))
    else $error("Sticky error flag dropped");
  c_long: cover property ($rose(dqOe) && !chopActive);
  c_chop: cover property ($rose(dqOe) && chopActive);
  c_async: cover property ($rose(asyncTermination));
endmodule

bind dbot_core dbot_checker u_dbot_checker (.clk(clk), .rstn(rstn),
  .burstLenField(burstLenField), .clockEnable(clockEnable),
  .storeReady(storeReady), .dqOut(dqOut), .dqOe(dqOe),
  .storeValid(storeValid), .storeData(storeData), .chopActive(chopActive),
  .asyncTermination(asyncTermination), .termHoldError(termHoldError),
  .powerDownError(powerDownError), .writeOverflow(writeOverflow));

// [verification/dbot_ctrl_model.sv]
// Controller model: commands, termination, clock enable, write data.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
module dbot_ctrl_model #(
  parameter int WLAT = 5,
  parameter int GAP = 6
) (
  // Clock
  input wire logic clk,
  // Command pins
  output logic csN,
  output logic [2:0] cmd,
  output logic [2:0] bankAddr,
  output logic chopBit,
  output logic termEn,
  output logic cke,
  // Write data
  output logic [dbot_pkg::DQ_W-1:0] dqIn
);
  initial begin
    csN = 1'b1;
    cmd = dbot_pkg::CMD_NOP;
    bankAddr = 3'h0;
    chopBit = 1'b0;
    termEn = 1'b0;
    cke = 1'b1;
    dqIn = '0;
  end
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic issue(input logic [2:0] c, input logic ch);
    csN = 1'b0;
    cmd = c;
    chopBit = ch;
    bankAddr = 3'($urandom);
    idle(1);
    csN = 1'b1;
    cmd = dbot_pkg::CMD_NOP;
  endtask
  task automatic write(input logic ch, input int n, input logic [15:0] d [8]);
    termEn = 1'b1;
    issue(dbot_pkg::CMD_WR, ch);
    idle(WLAT - 1);
    for (int i = 0; i < n; i++) begin
      dqIn = d[i];
      idle(1);
    end
    // Released line inverts so a stale beat never looks valid
    dqIn = ~dqIn;
    idle(GAP);
    termEn = 1'b0;
    idle(1);
  endtask
  task automatic termPulse(input int n);
    termEn = 1'b1;
    idle(n);
    termEn = 1'b0;
    idle(1);
  endtask
  task automatic powerDown(input logic [2:0] last);
    idle(1);
    issue(last, 1'b0);
    cke = 1'b0;
    idle(8);
    cke = 1'b1;
    idle(8);
  endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the timing core driven by a controller model.
// Assumes package, core, buffer, checker and model compiled first.
`timescale 1ns/1ps
module tb_top;
  localparam int WLAT = 5;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] burstLenField = 2'h0;
  logic storeReady = 1'b0;
  logic stallAll = 1'b0;
  logic sawAsync = 1'b0;
  logic pick;
  logic [15:0] arrayRdData = 16'h0000;
  logic [dbot_pkg::LAT_W-1:0] addLat = 6'h00;
  logic [dbot_pkg::LAT_W-1:0] colLat = 6'h05;
  logic [dbot_pkg::LAT_W-1:0] wcolLat = 6'h05;
  logic allBanks = 1'b0;
  logic [15:0] lastRd = 16'h0000;
  int n;
  logic csN, chopBit, termEn, cke, dqOe, storeValid, chopActive;
  logic asyncTermination, termHoldError, powerDownError, writeOverflow;
  logic [2:0] cmd, bankAddr;
  logic [15:0] dqIn, dqOut, storeData;
  logic [15:0] wq[$];
  int lq[$];
  int run = 0;
  int aRun = 0;
  int miscompares = 0;
  int numChecks = 0;
  logic [15:0] d [8];
  logic [1:0] flds [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  logic chops [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  int lens [5] = '{8, 4, 8, 4, 8};

  always #25 clk = ~clk;

  dbot_core u_dbot_core (.clk(clk), .rstn(rstn),
    .burstLenField(burstLenField), .additiveLatency(addLat),
    .columnLatency(colLat), .writeColumnLatency(wcolLat), .csN(csN),
    .rasN(cmd[2]), .casN(cmd[1]), .weN(cmd[0]), .bankAddr(bankAddr),
    .allBanksBit(allBanks), .burstChopAddressBit(chopBit),
    .terminationEnable(termEn), .clockEnable(cke), .dqIn(dqIn),
    .dqOut(dqOut), .dqOe(dqOe), .arrayRdData(arrayRdData),
    .storeValid(storeValid), .storeData(storeData),
    .storeReady(storeReady), .chopActive(chopActive),
    .asyncTermination(asyncTermination), .termHoldError(termHoldError),
    .powerDownError(powerDownError), .writeOverflow(writeOverflow));

  dbot_ctrl_model #(.WLAT(WLAT)) u_dbot_ctrl_model (.clk(clk), .csN(csN),
    .cmd(cmd), .bankAddr(bankAddr), .chopBit(chopBit), .termEn(termEn),
    .cke(cke), .dqIn(dqIn));

  //****************************************************
  // Stimulus, scoreboard and reporting
  //****************************************************
  always @(posedge clk) begin
    #1;
    arrayRdData = 16'($urandom);
    storeReady = !stallAll && 1'($urandom);
  end

  always @(posedge clk) begin
    if (!rstn) begin
      run = 0;
      aRun = 0;
    end else begin
      if (dqOe)
        check(dqOut, lastRd);
      lastRd = arrayRdData;
      if (storeValid && storeReady)
        check(storeData, wq.size() ? wq.pop_front() : 16'hxxxx);
      if (dqOe)
        run++;
      else if (run != 0) begin
        check(16'(run), lq.size() ? 16'(lq.pop_front()) : 16'hxxxx);
        run = 0;
      end
      if (asyncTermination) begin
        aRun++;
        sawAsync = 1'b1;
      end else if (aRun != 0) begin
        check(16'(aRun), 16'(WLAT - 1));
        aRun = 0;
      end
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic doReset();
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    u_dbot_ctrl_model.idle(3);
  endtask

  task automatic drain(input string name);
    for (int i = 0; i < 400 && (wq.size() || lq.size()); i++)
      @(posedge clk);
    #1;
    if (wq.size() || lq.size()) begin
      miscompares++;
      conclude();
    end else begin
      $display("Test %0s done", name);
    end
  endtask

  initial begin
    #1000000;
    miscompares++;
    conclude();
  end

  initial begin
    void'($urandom(32'hd3455eed));
    doReset();
    check(16'({dqOe, storeValid, chopActive}), 16'h0000);
    for (int i = 0; i < 5; i++) begin
      burstLenField = flds[i];
      foreach (d[k]) d[k] = 16'($urandom);
      for (int k = 0; k < lens[i]; k++) wq.push_back(d[k]);
      u_dbot_ctrl_model.write(chops[i], lens[i], d);
      lq.push_back(lens[i]);
      u_dbot_ctrl_model.issue(dbot_pkg::CMD_RD, chops[i]);
      u_dbot_ctrl_model.idle(14);
      check(16'(chopActive), 16'(lens[i] == 4));
    end
    drain("fixed and per-command bursts");
    burstLenField = dbot_pkg::BLF_PERCMD;
    for (int i = 0; i < 6; i++) begin
      pick = 1'($urandom);
      addLat = 6'($urandom % 3);
      lq.push_back(pick ? 8 : 4);
      u_dbot_ctrl_model.issue(dbot_pkg::CMD_RD, pick);
      for (n = 0; n < 20 && !dqOe; n++) u_dbot_ctrl_model.idle(1);
      check(16'(n), 16'(addLat + colLat + 3));
      u_dbot_ctrl_model.idle(8);
    end
    addLat = 6'h00;
    drain("per-command read mix");
    u_dbot_ctrl_model.termPulse(4);
    u_dbot_ctrl_model.idle(4);
    check(16'(termHoldError), 16'h0000);
    u_dbot_ctrl_model.issue(dbot_pkg::CMD_ACT, 1'b0);
    u_dbot_ctrl_model.powerDown(dbot_pkg::CMD_NOP);
    check(16'({sawAsync, powerDownError}), 16'h0002);
    allBanks = 1'b1;
    u_dbot_ctrl_model.issue(dbot_pkg::CMD_PRE, 1'b0);
    allBanks = 1'b0;
    u_dbot_ctrl_model.powerDown(dbot_pkg::CMD_ZQ);
    check(16'(powerDownError), 16'h0000);
    u_dbot_ctrl_model.termPulse(2);
    u_dbot_ctrl_model.issue(dbot_pkg::CMD_ACT, 1'b0);
    u_dbot_ctrl_model.powerDown(dbot_pkg::CMD_ZQ);
    check(16'({termHoldError, powerDownError}), 16'h0003);
    drain("termination and power-down");
    stallAll = 1'b1;
    burstLenField = dbot_pkg::BLF_FIXED8;
    repeat (3) u_dbot_ctrl_model.write(1'b1, 8, d);
    check(16'(writeOverflow), 16'h0001);
    doReset();
    stallAll = 1'b0;
    check(16'({writeOverflow, termHoldError, powerDownError}), 16'h0000);
    drain("overflow and second reset");
    conclude();
  end
endmodule
